/* File: irq_ctrl_pkg.sv */
package irq_ctrl_pkg;
  // ==========================================================
  // sizes and timing
  localparam int NUM_SRC = 13;
  localparam int LVL_W = 3;
  localparam int NUM_LVL = 5;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MEM_CYCLE_NS = 40;
  localparam int CLKS_PER_MEM = (MEM_CYCLE_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam int MDIV_W = $clog2(CLKS_PER_MEM);
  localparam logic [MDIV_W-1:0] MDIV_LAST = MDIV_W'(CLKS_PER_MEM - 1);
  localparam logic [LVL_W-1:0] LVL_PF = 3'h4;
  localparam logic [LVL_W-1:0] LVL_RST = 3'h0;
  // ==========================================================
  // register map
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] A_T01_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] A_T2_CTRL = 4'h1;
  localparam logic [ADDR_W-1:0] A_IRQ_EN = 4'h2;
  localparam logic [ADDR_W-1:0] A_XIRQ_EN = 4'h3;
  localparam logic [ADDR_W-1:0] A_PRIO_LO = 4'h4;
  localparam logic [ADDR_W-1:0] A_PRIO_HI = 4'h5;
  localparam logic [ADDR_W-1:0] A_XPRIO_LO = 4'h6;
  localparam logic [ADDR_W-1:0] A_XPRIO_HI = 4'h7;
  localparam logic [ADDR_W-1:0] A_XFLAGS = 4'h8;
  localparam logic [ADDR_W-1:0] A_WDOG = 4'h9;
  localparam logic [ADDR_W-1:0] A_SERIAL = 4'hA;
  localparam logic [ADDR_W-1:0] A_IN_SERVICE = 4'hB;
  // ==========================================================
  // field positions
  localparam int B_IT0 = 0;
  localparam int B_EXT0 = 1;
  localparam int B_IT1 = 2;
  localparam int B_EXT1 = 3;
  localparam int B_TF0 = 5;
  localparam int B_TF1 = 7;
  localparam int B_CAPSEL = 0;
  localparam int B_T2XEN = 3;
  localparam int B_UPDN = 4;
  localparam int B_T2XF = 6;
  localparam int B_TF2 = 7;
  localparam int B_GIE = 7;
  localparam int B_XFLAG = 4;
  localparam int B_EWT = 1;
  localparam int B_WDIF = 3;
  localparam int B_PFI = 4;
  localparam int B_POWERFAIL_IRQ_ENABLE = 5;
  localparam int B_RX0 = 0;
  localparam int B_TX0 = 1;
  localparam int B_RX1 = 2;
  localparam int B_TX1 = 3;
  // ==========================================================
  // sources in natural order, index 0 wins ties
  localparam int SRC_PF = 0;
  localparam int SRC_EX0 = 1;
  localparam int SRC_T0 = 2;
  localparam int SRC_EX1 = 3;
  localparam int SRC_T2 = 6;
  localparam logic [NUM_SRC*8-1:0] VECTORS = {
    8'h63, 8'h5B, 8'h53, 8'h4B, 8'h43, 8'h3B, 8'h2B,
    8'h23, 8'h1B, 8'h13, 8'h0B, 8'h03, 8'h33};
  localparam logic [5:0] EXT_POS_EDGE = 6'h14;
endpackage

/* File: irq_ctrl.sv */
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module irq_ctrl (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic [irq_ctrl_pkg::ADDR_W-1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  output logic [7:0] RDATA,
  input wire logic INSTR_LAST,
  input wire logic INSTR_RETURN_FROM_INTERRUPT,
  output logic MEM_STROBE,
  output logic CALL_REQ,
  output logic [7:0] CALL_VECTOR,
  output logic [irq_ctrl_pkg::NUM_LVL-1:0] IN_SERVICE,
  input wire logic TMR0_OVF,
  input wire logic TMR1_OVF,
  input wire logic TMR2_OVF,
  input wire logic WDOG_TIMEOUT,
  input wire logic SER0_RX_DONE,
  input wire logic SER0_TX_DONE,
  input wire logic SER1_RX_DONE,
  input wire logic SER1_TX_DONE,
  input wire logic [5:0] EXT_INT_PIN,
  input wire logic TIMER2_EXTERNAL_PIN,
  input wire logic SUPPLY_LOW,
  output logic WATCHDOG_RESET_ENABLE
);
  import irq_ctrl_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [MDIV_W-1:0] mdiv;
    logic [5:0] ext_s1;
    logic [5:0] ext_s2;
    logic [5:0] ext_prev;
    logic t2x_s1;
    logic t2x_s2;
    logic t2x_prev;
    logic pf_s1;
    logic pf_s2;
    logic [7:0] t01;
    logic [7:0] t2;
    logic [7:0] irq_en;
    logic [4:0] xirq_en;
    logic [6:0] plo;
    logic [6:0] phi;
    logic [4:0] xplo;
    logic [4:0] xphi;
    logic [3:0] xflag;
    logic pfi;
    logic powerfail_irq_enable;
    logic wdif;
    logic watchdog_reset_enable;
    logic [3:0] ser;
    logic [NUM_LVL-1:0] isr;
    logic abort;
    logic call;
    logic [7:0] vec;
    logic [7:0] rdata;
  } state_t;

  state_t q;
  state_t n;

  // ==========================================================
  // helpers
  function automatic logic [LVL_W-1:0] top_level(
    input logic [NUM_LVL-1:0] s);
    top_level = '0;
    for (int i = 0; i < NUM_LVL; i++) begin
      if (s[i]) begin
        top_level = LVL_W'(i);
      end
    end
  endfunction

  function automatic logic is_prio_addr(input logic [ADDR_W-1:0] a);
    is_prio_addr = (a == A_IRQ_EN) || (a == A_XIRQ_EN) ||
                   (a == A_PRIO_LO) || (a == A_PRIO_HI) ||
                   (a == A_XPRIO_LO) || (a == A_XPRIO_HI);
  endfunction

  // ==========================================================
  // arbitration
  logic mem_en;
  logic eval;
  logic prio_wr;
  logic [NUM_SRC-1:0] req;
  logic [NUM_SRC-1:0] src_en;
  logic [NUM_SRC-1:0] gate;
  logic [6:0] plo_all;
  logic [6:0] phi_all;
  logic [11:0] plo_cat;
  logic [11:0] phi_cat;
  logic [LVL_W-1:0] lvl [NUM_SRC];
  logic win_valid;
  logic [LVL_W-1:0] win_lvl;
  logic [3:0] win_idx;
  logic [LVL_W:0] cur_eff;
  logic ack;
  logic [5:0] ext_edge;
  logic t2x_fall;

  assign mem_en = (q.mdiv == MDIV_LAST);
  assign eval = mem_en && INSTR_LAST;
  assign prio_wr = WR_EN && is_prio_addr(ADDR);
  assign plo_all = q.plo;
  assign phi_all = q.phi;
  assign plo_cat = {q.xplo, plo_all};
  assign phi_cat = {q.xphi, phi_all};

  // pseudo edge: previous sample vs current synchronised sample
  assign ext_edge = (EXT_POS_EDGE & ~q.ext_prev & q.ext_s2) |
                    (~EXT_POS_EDGE & q.ext_prev & ~q.ext_s2);
  assign t2x_fall = q.t2x_prev && !q.t2x_s2;

  // flags in natural order
  assign req = {q.wdif, q.xflag[3:0],
                q.ser[B_RX1] | q.ser[B_TX1],
                q.t2[B_TF2] | q.t2[B_T2XF],
                q.ser[B_RX0] | q.ser[B_TX0],
                q.t01[B_TF1], q.t01[B_EXT1], q.t01[B_TF0],
                q.t01[B_EXT0], q.pfi};
  assign src_en = {q.xirq_en, q.irq_en[6:0], q.powerfail_irq_enable};

  generate
    for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
      if (g == SRC_PF) begin : g_pf
        assign lvl[g] = LVL_PF;
        assign gate[g] = req[g] && src_en[g];
      end else begin : g_mask
        assign lvl[g] = {1'b0, phi_cat[g-1], plo_cat[g-1]};
        assign gate[g] = req[g] && src_en[g] && q.irq_en[B_GIE];
      end
    end
  endgenerate

  always_comb begin
    win_valid = 1'b0;
    win_lvl = '0;
    win_idx = '0;
    // descending scan with >= leaves the lowest natural index on ties
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (gate[i] && (!win_valid || lvl[i] >= win_lvl)) begin
        win_valid = 1'b1;
        win_lvl = lvl[i];
        win_idx = 4'(i);
      end
    end
  end

  assign cur_eff = (q.isr == '0) ? '0 : {1'b0, top_level(q.isr)} + 1'b1;
  assign ack = eval && win_valid && !INSTR_RETURN_FROM_INTERRUPT && !q.abort && !prio_wr &&
               (({1'b0, win_lvl} + 1'b1) > cur_eff);

  // ==========================================================
  // next state
  always_comb begin
    n = q;
    n.mdiv = mem_en ? '0 : q.mdiv + 1'b1;
    n.ext_s1 = EXT_INT_PIN;
    n.ext_s2 = q.ext_s1;
    n.ext_prev = q.ext_s2;
    n.t2x_s1 = TIMER2_EXTERNAL_PIN;
    n.t2x_s2 = q.t2x_s1;
    n.t2x_prev = q.t2x_s2;
    n.pf_s1 = SUPPLY_LOW;
    n.pf_s2 = q.pf_s1;

    // software first, hardware afterwards so that hardware wins
    if (WR_EN) begin
      case (ADDR)
        A_T01_CTRL: n.t01 = WDATA;
        A_T2_CTRL: n.t2 = WDATA;
        A_IRQ_EN: n.irq_en = WDATA;
        A_XIRQ_EN: n.xirq_en = WDATA[4:0];
        A_PRIO_LO: n.plo = WDATA[6:0];
        A_PRIO_HI: n.phi = WDATA[6:0];
        A_XPRIO_LO: n.xplo = WDATA[4:0];
        A_XPRIO_HI: n.xphi = WDATA[4:0];
        A_XFLAGS: n.xflag = WDATA[7:B_XFLAG];
        A_WDOG: begin
          n.pfi = WDATA[B_PFI];
          n.powerfail_irq_enable = WDATA[B_POWERFAIL_IRQ_ENABLE];
          n.wdif = WDATA[B_WDIF];
          n.watchdog_reset_enable = WDATA[B_EWT];
        end
        A_SERIAL: n.ser = WDATA[3:0];
        default: ;
      endcase
    end

    // ack clears come before event sets so a coincident event survives
    if (ack && win_idx == 4'(SRC_T0)) begin
      n.t01[B_TF0] = 1'b0;
    end
    if (ack && win_idx == 4'(SRC_T0 + 2)) begin
      n.t01[B_TF1] = 1'b0;
    end
    if (TMR0_OVF) begin
      n.t01[B_TF0] = 1'b1;
    end
    if (TMR1_OVF) begin
      n.t01[B_TF1] = 1'b1;
    end

    // external 0/1: edge mode latches and clears on ack, level mode tracks
    if (q.t01[B_IT0]) begin
      if (ack && win_idx == 4'(SRC_EX0)) begin
        n.t01[B_EXT0] = 1'b0;
      end
      if (ext_edge[0]) begin
        n.t01[B_EXT0] = 1'b1;
      end
    end else begin
      n.t01[B_EXT0] = !q.ext_s2[0];
    end
    if (q.t01[B_IT1]) begin
      if (ack && win_idx == 4'(SRC_EX1)) begin
        n.t01[B_EXT1] = 1'b0;
      end
      if (ext_edge[1]) begin
        n.t01[B_EXT1] = 1'b1;
      end
    end else begin
      n.t01[B_EXT1] = !q.ext_s2[1];
    end
    for (int i = 0; i < 4; i++) begin
      if (ext_edge[i+2]) begin
        n.xflag[i] = 1'b1;
      end
    end

    // timer 2 flags are never touched by an ack
    if (TMR2_OVF) begin
      n.t2[B_TF2] = 1'b1;
    end
    if (t2x_fall && q.t2[B_T2XEN] &&
        (q.t2[B_CAPSEL] || !q.t2[B_UPDN])) begin
      n.t2[B_T2XF] = 1'b1;
    end

    if (WDOG_TIMEOUT) begin
      n.wdif = 1'b1;
    end
    if (q.pf_s2) begin
      n.pfi = 1'b1;
    end

    // serial flags set on whole-word done pulses, cleared by software only
    if (SER0_RX_DONE) begin
      n.ser[B_RX0] = 1'b1;
    end
    if (SER0_TX_DONE) begin
      n.ser[B_TX0] = 1'b1;
    end
    if (SER1_RX_DONE) begin
      n.ser[B_RX1] = 1'b1;
    end
    if (SER1_TX_DONE) begin
      n.ser[B_TX1] = 1'b1;
    end

    // abort covers the whole instruction that wrote A_IRQ_EN, A_XIRQ_EN or a priority register
    if (prio_wr) begin
      n.abort = 1'b1;
    end
    if (eval) begin
      n.abort = 1'b0;
    end

    if (eval && INSTR_RETURN_FROM_INTERRUPT && q.isr != '0) begin
      n.isr[top_level(q.isr)] = 1'b0;
    end
    // vector is latched, so a later flag clear cannot cancel the call
    if (ack) begin
      n.isr[win_lvl] = 1'b1;
      n.vec = VECTORS[win_idx*8 +: 8];
    end
    if (mem_en) begin
      n.call = ack;
    end

    n.rdata = '0;
    if (RD_EN) begin
      case (ADDR)
        A_T01_CTRL: n.rdata = q.t01;
        A_T2_CTRL: n.rdata = q.t2;
        A_IRQ_EN: n.rdata = q.irq_en;
        A_XIRQ_EN: n.rdata = {3'h0, q.xirq_en};
        A_PRIO_LO: n.rdata = {1'b0, q.plo};
        A_PRIO_HI: n.rdata = {1'b0, q.phi};
        A_XPRIO_LO: n.rdata = {3'h0, q.xplo};
        A_XPRIO_HI: n.rdata = {3'h0, q.xphi};
        A_XFLAGS: n.rdata = {q.xflag, 4'h0};
        A_WDOG: n.rdata = {2'h0, q.powerfail_irq_enable, q.pfi, q.wdif, 1'b0, q.watchdog_reset_enable, 1'b0};
        A_SERIAL: n.rdata = {4'h0, q.ser};
        A_IN_SERVICE: n.rdata = {3'h0, q.isr};
        default: n.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      q <= '0; // all priority bits and enables clear
      q.ext_s1 <= 6'h3F;
      q.ext_s2 <= 6'h3F;
      q.ext_prev <= 6'h3F;
      q.t2x_s1 <= 1'b1;
      q.t2x_s2 <= 1'b1;
      q.t2x_prev <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign RDATA = q.rdata;
  assign MEM_STROBE = mem_en;
  assign CALL_REQ = q.call;
  assign CALL_VECTOR = q.vec;
  assign IN_SERVICE = q.isr;
  assign WATCHDOG_RESET_ENABLE = q.watchdog_reset_enable;

  // ==========================================================
  // checks
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);

  sequence s_eval_win;
    eval && !INSTR_RETURN_FROM_INTERRUPT && !q.abort && !prio_wr && win_valid;
  endsequence
  sequence s_call_hold;
    CALL_REQ [*4];
  endsequence

  a_call_from_eval: assert property (
    $rose(CALL_REQ) |-> $past(ack) && $past(eval))
    else $error("call raised without a final-cycle acknowledge");
  a_call_one_memcycle: assert property (
    ack |=> s_call_hold)
    else $error("forced call did not span one memory cycle");
  a_tmr0_clear: assert property (
    ack && win_idx == 4'(SRC_T0) && !TMR0_OVF |=> !q.t01[B_TF0])
    else $error("timer 0 flag kept after vectoring");
  a_tmr2_kept: assert property (
    ack && win_idx == 4'(SRC_T2) && !WR_EN && q.t2[B_TF2]
    |=> q.t2[B_TF2])
    else $error("timer 2 flag lost on vectoring");
  a_tmr1_set: assert property (
    TMR1_OVF |=> q.t01[B_TF1])
    else $error("timer 1 overflow lost");
  a_pf_level: assert property (
    q.pf_s2 |=> q.pfi)
    else $error("power-fail flag dropped while supply low");
  a_global_gate: assert property (
    ack && win_idx != 4'(SRC_PF) |-> q.irq_en[B_GIE])
    else $error("maskable source acknowledged with global enable off");
  a_abort_blocks: assert property (
    prio_wr |-> !ack ##1 (q.abort || $past(eval)))
    else $error("selection not suppressed by enable or priority write");
  a_nest_higher: assert property (
    s_eval_win |-> ack == ((q.isr >> win_lvl) == '0))
    else $error("eligible higher request was not taken");
  a_return_from_interrupt_pops: assert property (
    eval && INSTR_RETURN_FROM_INTERRUPT && q.isr != '0
    |=> $countones(q.isr) == $countones($past(q.isr)) - 1)
    else $error("return did not close one in-service level");
  a_tx_flag: assert property (
    q.ser[B_TX0] && !WR_EN |=> q.ser[B_TX0])
    else $error("serial flag cleared by hardware");
endmodule

/* File: core_model.sv */
`timescale 1ns/10ps
// ======================================
// core side
// ends an instruction on every memory cycle unless held by stall;
// never presents a final cycle while the forced call is running
module core_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic strobe,
  input wire logic call,
  input wire logic stall,
  input wire logic return_from_interrupt_go,
  output logic last,
  output logic return_from_interrupt
);
  logic return_from_interrupt_q;
  assign last = !stall && !call;
  assign return_from_interrupt = return_from_interrupt_q;
  // the return stays pending until a final cycle carries it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      return_from_interrupt_q <= 1'b0;
    end else if (return_from_interrupt_go) begin
      return_from_interrupt_q <= 1'b1;
    end else if (strobe && last) begin
      return_from_interrupt_q <= 1'b0;
    end
  end
endmodule

/* File: tb.sv */
`timescale 1ns/10ps
module tb;
  import irq_ctrl_pkg::*;
  // ======================================
  // signals
  logic clock, rst, wr_en, rd_en, stall, return_from_interrupt_go, supply_low, t2_pin;
  logic strobe, call, wd_rst_en, last, return_from_interrupt;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata, rdata, vec, evt;
  logic [5:0] ext_pin;
  logic [NUM_LVL-1:0] insvc;
  int n_errors = 0;
  int n_checks = 0;
  irq_ctrl DUT (
    .CLOCK(clock), .SYS_RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR_EN(wr_en), .RD_EN(rd_en), .RDATA(rdata), .INSTR_LAST(last),
    .INSTR_RETURN_FROM_INTERRUPT(return_from_interrupt), .MEM_STROBE(strobe), .CALL_REQ(call),
    .CALL_VECTOR(vec), .IN_SERVICE(insvc), .TMR0_OVF(evt[0]),
    .TMR1_OVF(evt[1]), .TMR2_OVF(evt[2]), .WDOG_TIMEOUT(evt[3]),
    .SER0_RX_DONE(evt[4]), .SER0_TX_DONE(evt[5]),
    .SER1_RX_DONE(evt[6]), .SER1_TX_DONE(evt[7]),
    .EXT_INT_PIN(ext_pin), .TIMER2_EXTERNAL_PIN(t2_pin),
    .SUPPLY_LOW(supply_low), .WATCHDOG_RESET_ENABLE(wd_rst_en)
  );
  core_model core (
    .clock(clock), .rst(rst), .strobe(strobe), .call(call),
    .stall(stall), .return_from_interrupt_go(return_from_interrupt_go), .last(last), .return_from_interrupt(return_from_interrupt)
  );
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ======================================
  // shared tasks
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic pulse(input logic [7:0] m);
    @(posedge clock);
    evt <= m;
    @(posedge clock);
    evt <= 8'h00;
    #1;
  endtask
  task automatic no_call(input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
      chk(call, 8'h00);
    end
  endtask
  // n_ev > 0 also checks how many evaluations it took
  task automatic wait_call(input logic [7:0] v, input int n_ev);
    int ev;
    ev = 0;
    repeat (200) begin
      #1;
      if (call === 1'b1) break;
      if (strobe === 1'b1 && last === 1'b1) ev++;
      @(posedge clock);
    end
    chk(vec, v);
    if (n_ev > 0) chk(8'(ev), 8'(n_ev));
    // the call holds for exactly one memory cycle
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      #1;
      chk(call, 8'(i < 3));
    end
  endtask
  task automatic do_return_from_interrupt;
    @(posedge clock);
    return_from_interrupt_go <= 1'b1;
    @(posedge clock);
    return_from_interrupt_go <= 1'b0;
    repeat (8) begin
      @(posedge clock);
      #1;
      if (return_from_interrupt !== 1'b1) break;
    end
  endtask
  // ======================================
  // scenarios
  task automatic t_reset;
    int n_st = 0;
    for (int a = 4; a < 8; a++) rchk(ADDR_W'(a), 8'h00);
    rchk(4'hC, 8'h00);
    chk(insvc, 8'h00);
    wr(A_WDOG, 8'h02);
    chk(wd_rst_en, 8'h01);
    wr(A_WDOG, 8'h00);
    // one strobe per four clocks
    repeat (8) begin
      @(posedge clock);
      #1;
      if (strobe === 1'b1) n_st++;
    end
    chk(8'(n_st), 8'h02);
  endtask
  task automatic t_flags;
    pulse(8'h01);
    no_call(16);
    rchk(A_T01_CTRL, 8'h20);
    @(posedge clock);
    addr <= A_T01_CTRL;
    wdata <= 8'h00;
    wr_en <= 1'b1;
    evt <= 8'h02;
    @(posedge clock);
    wr_en <= 1'b0;
    evt <= 8'h00;
    rchk(A_T01_CTRL, 8'h80);
    @(posedge clock);
    ext_pin[0] <= 1'b0;
    // two sync flops plus the flag register
    no_call(3);
    rchk(A_T01_CTRL, 8'h82);
    @(posedge clock);
    ext_pin[0] <= 1'b1;
    no_call(6);
    rchk(A_T01_CTRL, 8'h80);
  endtask
  task automatic t_call;
    wr(A_T01_CTRL, 8'h20);
    wr(A_IRQ_EN, 8'h02);
    no_call(24);
    wr(A_IRQ_EN, 8'h82);
    wait_call(8'h0B, 0);
    rchk(A_T01_CTRL, 8'h00);
    chk(insvc, 8'h01);
    do_return_from_interrupt;
    chk(insvc, 8'h00);
  endtask
  task automatic t_prio;
    @(posedge clock);
    stall <= 1'b1;
    wr(A_PRIO_LO, 8'h0A);
    wr(A_IRQ_EN, 8'h8A);
    pulse(8'h03);
    @(posedge clock);
    stall <= 1'b0;
    wait_call(8'h0B, 2);
    chk(insvc, 8'h02);
    no_call(24);
    wr(A_IRQ_EN, 8'h0A);
    wr(A_WDOG, 8'h20);
    @(posedge clock);
    supply_low <= 1'b1;
    wait_call(8'h33, 0);
    chk(insvc, 8'h12);
    wr(A_WDOG, 8'h20);
    rchk(A_WDOG, 8'h30);
    @(posedge clock);
    supply_low <= 1'b0;
    no_call(8);
    wr(A_WDOG, 8'h00);
    wr(A_IRQ_EN, 8'h8A);
    do_return_from_interrupt;
    chk(insvc, 8'h02);
    do_return_from_interrupt;
    wait_call(8'h1B, 0);
    do_return_from_interrupt;
  endtask
  task automatic t_misc;
    wr(A_T2_CTRL, 8'h09);
    @(posedge clock);
    t2_pin <= 1'b0;
    pulse(8'hFC);
    rchk(A_T2_CTRL, 8'hC9);
    rchk(A_SERIAL, 8'h0F);
    rchk(A_WDOG, 8'h08);
    wr(A_XIRQ_EN, 8'h10);
    wr(A_IRQ_EN, 8'hB0);
    wait_call(8'h23, 0);
    rchk(A_SERIAL, 8'h0F);
    wr(A_SERIAL, 8'h00);
    do_return_from_interrupt;
    wait_call(8'h2B, 0);
    rchk(A_T2_CTRL, 8'hC9);
    wr(A_T2_CTRL, 8'h09);
    do_return_from_interrupt;
    wait_call(8'h63, 0);
    wr(A_WDOG, 8'h00);
    chk(insvc, 8'h01);
    do_return_from_interrupt;
    no_call(24);
  endtask
  task automatic t_edge;
    wr(A_T01_CTRL, 8'h01);
    wr(A_IRQ_EN, 8'h81);
    // up/down counting blocks the external flag
    wr(A_T2_CTRL, 8'h18);
    @(posedge clock);
    t2_pin <= 1'b1;
    no_call(4);
    @(posedge clock);
    t2_pin <= 1'b0;
    no_call(4);
    rchk(A_T2_CTRL, 8'h18);
    wr(A_T2_CTRL, 8'h08);
    @(posedge clock);
    t2_pin <= 1'b1;
    no_call(4);
    @(posedge clock);
    t2_pin <= 1'b0;
    no_call(4);
    rchk(A_T2_CTRL, 8'h48);
    wr(A_T2_CTRL, 8'h00);
    // edge mode: ext0 latches and clears on vectoring
    @(posedge clock);
    ext_pin <= 6'h32;
    wait_call(8'h03, 0);
    rchk(A_T01_CTRL, 8'h01);
    rchk(A_XFLAGS, 8'h20);
    @(posedge clock);
    ext_pin <= 6'h3F;
    no_call(4);
    rchk(A_XFLAGS, 8'h30);
    do_return_from_interrupt;
    no_call(24);
    wr(A_XFLAGS, 8'h00);
    wr(A_T01_CTRL, 8'h00);
  endtask
  // ======================================
  // main sequence and watchdog
  initial begin
    rst = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = '0;
    wdata = 8'h00;
    evt = 8'h00;
    stall = 1'b0;
    return_from_interrupt_go = 1'b0;
    supply_low = 1'b0;
    t2_pin = 1'b1;
    ext_pin = 6'h3F;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_reset;
    t_flags;
    t_call;
    t_prio;
    t_misc;
    t_edge;
    report_and_stop;
  end
  // whole run is a few hundred clocks
  initial begin
    #200000;
    n_errors++;
    report_and_stop;
  end
endmodule
